// File: gsw_defines.vh
/*
 * constants of the gain switch and speed feedback selector: register
 * offsets, reset values, field positions and scaling shifts.
 * assumes inclusion by bare name from the design files only.
 */
`ifndef GSW_DEFINES_VH
`define GSW_DEFINES_VH

// ----------------------------------------------------------------
// register word indexes (byte address = index * 4)
// ----------------------------------------------------------------
`define GSW_IDX_SPD_GAIN_A     5'h00
`define GSW_IDX_INTEG_A        5'h01
`define GSW_IDX_POS_GAIN_A     5'h02
`define GSW_IDX_TQ_FILT_A      5'h03
`define GSW_IDX_SPD_GAIN_B     5'h04
`define GSW_IDX_INTEG_B        5'h05
`define GSW_IDX_POS_GAIN_B     5'h06
`define GSW_IDX_TQ_FILT_B      5'h07
`define GSW_IDX_TQ_THR         5'h08
`define GSW_IDX_DEV_THR        5'h09
`define GSW_IDX_ACC_THR        5'h0a
`define GSW_IDX_SREF_THR       5'h0b
`define GSW_IDX_PREF_THR       5'h0c
`define GSW_IDX_ASPD_THR       5'h0d
`define GSW_IDX_MODE           5'h0e
`define GSW_IDX_DELAY          5'h0f
`define GSW_IDX_RAMP           5'h10
`define GSW_IDX_HYST           5'h11
`define GSW_IDX_ENC_FILT       5'h12
`define GSW_IDX_OBS_GAIN       5'h13
`define GSW_IDX_FB_SEL         5'h14
`define GSW_NUM_CFG            21
`define GSW_IDX_STATUS         5'h18
`define GSW_IDX_POS_GAIN_NOW   5'h19
`define GSW_IDX_FB_SPEED       5'h1a
`define GSW_IDX_OBS_SPEED      5'h1b
`define GSW_IDX_ENC_SPEED      5'h1c

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define GSW_RST_SPD_GAIN       16'h0190
`define GSW_RST_INTEG          16'h07d0
`define GSW_RST_POS_GAIN       16'h0190
`define GSW_RST_TQ_FILT        16'h0064
`define GSW_RST_THR            16'h00c8
`define GSW_RST_ENC_FILT       16'h0004
`define GSW_RST_OBS_GAIN       16'h00c8
`define GSW_RST_ZERO           16'h0000

// ----------------------------------------------------------------
// gain switch mode codes
// ----------------------------------------------------------------
`define GSW_MODE_FIX_A         4'h0
`define GSW_MODE_EXT           4'h1
`define GSW_MODE_TQ            4'h2
`define GSW_MODE_DEV           4'h3
`define GSW_MODE_ACC           4'h4
`define GSW_MODE_SREF          4'h5
`define GSW_MODE_PREF          4'h6
`define GSW_MODE_ASPD          4'h7
`define GSW_MODE_PREF_ASPD     4'h8
`define GSW_MODE_FIX_B         4'h9
`define GSW_MODE_POS_DONE      4'ha

// ----------------------------------------------------------------
// status bits, scaling
// ----------------------------------------------------------------
`define GSW_ST_SET_B           0
`define GSW_ST_PENDING         1
`define GSW_ST_RAMPING         2
`define GSW_FRAC_BITS          8
`define GSW_OBS_GAIN_SHIFT     10
`define GSW_OBS_TQ_SHIFT       4

`endif

// File: gsw_host.sv
/* far side: control cycle pulse and a moving encoder.
   assumes one sys_clk domain; step is counts per tick. */
`timescale 1ns/100ps
`default_nettype none
module gsw_host (
    input  wire logic        sys_clk,
    input  wire logic        arst_n,
    input  wire logic [15:0] step,
    output logic             ctrl_tick,
    output logic [31:0]      encoder_pos
);
    // ------------------------------------------------------------
    // tick every 8 clocks, position moves once per tick
    // ------------------------------------------------------------
    logic [2:0] div_q;
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            div_q       <= 3'h0;
            ctrl_tick   <= 1'b0;
            encoder_pos <= 32'h0;
        end else begin
            div_q     <= div_q + 3'h1;
            ctrl_tick <= (div_q == 3'h7);
            if (ctrl_tick)
                encoder_pos <= encoder_pos + {16'h0, step};
        end
    end
endmodule
`default_nettype wire

// File: gsw_lpf.v
/*
 * first order low-pass stage for the encoder-derived speed.
 * assumes tick marks one control cycle, one sys_clk cycle wide.
 */
`timescale 1ns/100ps
`default_nettype none
`include "gsw_defines.vh"

module gsw_lpf (
    input  wire               sys_clk,
    input  wire               arst_n,
    input  wire               tick,
    input  wire signed [15:0] x_in,
    input  wire        [15:0] filt_time,
    output reg  signed [15:0] y_q
);

    // ------------------------------------------------------------
    // filter time to shift: bit length of bits 14:0, so time 0 passes through
    // ------------------------------------------------------------
    function [3:0] time_to_shift;
        input [15:0] t;
        integer i;
        begin
            time_to_shift = 4'h0;
            for (i = 0; i < 15; i = i + 1) begin
                if (t[i])
                    time_to_shift = i[3:0] + 4'h1;
            end
        end
    endfunction

    reg signed [31:0] acc_q;
    wire signed [31:0] x_ext;
    wire signed [31:0] err;
    wire        [3:0]  shift;

    assign x_ext = {{8{x_in[15]}}, x_in, {`GSW_FRAC_BITS{1'b0}}};
    assign err   = x_ext - acc_q;
    assign shift = time_to_shift(filt_time);

    // larger time, longer shift: smoother but more phase lag
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= 32'h0000_0000;
            y_q   <= 16'sh0000;
        end else if (tick) begin
            acc_q <= acc_q + (err >>> shift);
            y_q   <= acc_q[23:8];
        end
    end

endmodule
`default_nettype wire

// File: gsw_props.sv
/* checker: apb answer timing and gain set choice.
   assumes a bind onto gsw_top, one clock domain. */
`timescale 1ns/100ps
`default_nettype none
module gsw_props (
    input wire logic        sys_clk,
    input wire logic        arst_n,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        gain_sel_in,
    input wire logic        pos_done_in,
    input wire logic [15:0] position_loop_gain,
    input wire logic        gain_set_b
);
    // ------------------------------------------------------------
    // mode shadow and assertions
    // ------------------------------------------------------------
    logic [3:0] mode_q;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!arst_n);
    // shadow of the mode word, taken where the write lands
    always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            mode_q <= 4'h0;
        else if (psel && penable && pready && pwrite && paddr == 8'h38)
            mode_q <= pwdata[3:0];
    end
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence bad_rd_s;
        setup_s and (!pwrite && paddr >= 8'h80);
    endsequence
    setup_answer_a: assert property (setup_s |=> pready)
        else $error("no answer after setup");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("answer held too long");
    unmapped_read_a: assert property (bad_rd_s |=> pslverr && prdata == 0)
        else $error("unmapped read not refused");
    reset_set_a: assert property ($rose(arst_n) |->
        !gain_set_b && position_loop_gain == 16'h0190)
        else $error("second set after reset");
    fixed_first_a: assert property (
        $rose(gain_set_b) |-> mode_q != 4'h0) else $error("left first set");
    fixed_second_a: assert property (
        $fell(gain_set_b) |-> mode_q != 4'h9) else $error("left second set");
    ext_select_a: assert property (
        $rose(gain_set_b) && mode_q == 4'h1 |-> gain_sel_in)
        else $error("second set without select");
    pos_done_a: assert property (
        $rose(gain_set_b) && mode_q == 4'ha |-> pos_done_in)
        else $error("second set without done flag");
endmodule
bind gsw_top gsw_props u_props (.sys_clk, .arst_n, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .gain_sel_in,
    .pos_done_in, .position_loop_gain, .gain_set_b);
`default_nettype wire

// File: gsw_top.v
/*
 * gain set selection and speed feedback selection with apb registers.
 * assumes ctrl_tick pulses once per control cycle and every process
 * input is synchronous to sys_clk; magnitudes arrive unsigned.
 */
//
// How it works
// - two stored gain sets, one applied
// - first set applies by default, after reset
// - mode 0 always first set
// - mode 1 follows external select input
// - mode 10 follows positioning completed flag
// - modes 2..7 pick quantity and threshold
// - quantity above threshold plus hysteresis selects second set
// - hysteresis band stops threshold chatter
// - mode 8 position above threshold plus hysteresis
// - mode 8 actual speed above speed threshold
// - mode 8 needs both conditions true
// - mode 9 always second set
// - feedback select: 0 encoder, 1 observer
// - encoder speed is position difference per cycle
// - observer runs always, estimate readable
// - encoder speed low-pass with settable time
// - observer gain sets tracking strength
`timescale 1ns/100ps
`default_nettype none
`include "gsw_defines.vh"

module gsw_top (
    input  wire               sys_clk,
    input  wire               arst_n,
    input  wire               psel,
    input  wire               penable,
    input  wire               pwrite,
    input  wire        [7:0]  paddr,
    input  wire        [31:0] pwdata,
    output reg         [31:0] prdata,
    output reg                pready,
    output reg                pslverr,
    input  wire               ctrl_tick,
    input  wire               gain_sel_in,
    input  wire               pos_done_in,
    input  wire        [15:0] torque_ref_mag,
    input  wire        [15:0] pos_dev_mag,
    input  wire        [15:0] accel_mag,
    input  wire        [15:0] speed_ref_mag,
    input  wire        [15:0] pos_ref_mag,
    input  wire        [15:0] actual_speed_mag,
    input  wire        [31:0] encoder_pos,
    input  wire signed [15:0] torque_cmd,
    output reg         [15:0] speed_loop_gain,
    output reg         [15:0] speed_integral_time,
    output reg         [15:0] position_loop_gain,
    output reg         [15:0] torque_filter_time,
    output reg                gain_set_b,
    output reg  signed [15:0] speed_feedback,
    output reg  signed [15:0] observed_speed
);
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_WAIT = 2'h1;
    localparam [1:0] ST_RAMP = 2'h2;
    // ------------------------------------------------------------
    // register file
    // ------------------------------------------------------------
    function [15:0] rst_val;
        input [4:0] idx;
        begin
            case (idx)
                `GSW_IDX_SPD_GAIN_A, `GSW_IDX_SPD_GAIN_B:
                    rst_val = `GSW_RST_SPD_GAIN;
                `GSW_IDX_INTEG_A, `GSW_IDX_INTEG_B:
                    rst_val = `GSW_RST_INTEG;
                `GSW_IDX_POS_GAIN_A, `GSW_IDX_POS_GAIN_B:
                    rst_val = `GSW_RST_POS_GAIN;
                `GSW_IDX_TQ_FILT_A, `GSW_IDX_TQ_FILT_B:
                    rst_val = `GSW_RST_TQ_FILT;
                `GSW_IDX_TQ_THR, `GSW_IDX_DEV_THR, `GSW_IDX_ACC_THR,
                `GSW_IDX_SREF_THR, `GSW_IDX_PREF_THR, `GSW_IDX_ASPD_THR:
                    rst_val = `GSW_RST_THR;
                `GSW_IDX_ENC_FILT: rst_val = `GSW_RST_ENC_FILT;
                `GSW_IDX_OBS_GAIN: rst_val = `GSW_RST_OBS_GAIN;
                default:           rst_val = `GSW_RST_ZERO;
            endcase
        end
    endfunction
    // field width per register; upper bits read as zero
    function [15:0] field_mask;
        input [4:0] idx;
        begin
            case (idx)
                `GSW_IDX_MODE:     field_mask = 16'h000f;
                `GSW_IDX_FB_SEL:   field_mask = 16'h0001;
                `GSW_IDX_OBS_GAIN: field_mask = 16'h03ff;
                default:           field_mask = 16'hffff;
            endcase
        end
    endfunction
    reg [15:0] cfg_q [0:`GSW_NUM_CFG-1];
    wire [4:0] reg_idx;
    wire       cfg_hit;
    wire       wr_en;
    assign reg_idx = paddr[6:2];
    assign cfg_hit = (paddr[7] == 1'b0) && (paddr[1:0] == 2'h0) &&
                     (reg_idx < `GSW_NUM_CFG);
    assign wr_en   = psel && penable && pready && pwrite && cfg_hit;
    genvar gi;
    generate
        for (gi = 0; gi < `GSW_NUM_CFG; gi = gi + 1) begin : g_cfg
            always @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n)
                    cfg_q[gi] <= rst_val(gi[4:0]);
                else if (wr_en && reg_idx == gi[4:0])
                    cfg_q[gi] <= pwdata[15:0] & field_mask(gi[4:0]);
            end
        end
    endgenerate
    wire [3:0]  mode      = cfg_q[`GSW_IDX_MODE][3:0];
    wire [15:0] delay_cyc = cfg_q[`GSW_IDX_DELAY];
    wire [15:0] ramp_cyc  = cfg_q[`GSW_IDX_RAMP];
    wire [15:0] hyst      = cfg_q[`GSW_IDX_HYST];
    wire        fb_sel    = cfg_q[`GSW_IDX_FB_SEL][0];
    // ------------------------------------------------------------
    // switching condition
    // ------------------------------------------------------------
    reg [15:0] q_sel;
    reg [15:0] thr_sel;
    always @* begin
        case (mode)
            `GSW_MODE_TQ: begin
                q_sel   = torque_ref_mag;
                thr_sel = cfg_q[`GSW_IDX_TQ_THR];
            end
            `GSW_MODE_DEV: begin
                q_sel   = pos_dev_mag;
                thr_sel = cfg_q[`GSW_IDX_DEV_THR];
            end
            `GSW_MODE_ACC: begin
                q_sel   = accel_mag;
                thr_sel = cfg_q[`GSW_IDX_ACC_THR];
            end
            `GSW_MODE_SREF: begin
                q_sel   = speed_ref_mag;
                thr_sel = cfg_q[`GSW_IDX_SREF_THR];
            end
            `GSW_MODE_ASPD: begin
                q_sel   = actual_speed_mag;
                thr_sel = cfg_q[`GSW_IDX_ASPD_THR];
            end
            default: begin
                q_sel   = pos_ref_mag;
                thr_sel = cfg_q[`GSW_IDX_PREF_THR];
            end
        endcase
    end
    // 17-bit sum so a large hysteresis cannot wrap the upper edge
    wire [16:0] upper   = {1'b0, thr_sel} + {1'b0, hyst};
    wire        above   = {1'b0, q_sel} > upper;
    wire        at_low  = q_sel <= thr_sel;
    wire        spd_ok  = actual_speed_mag >
                          cfg_q[`GSW_IDX_ASPD_THR];
    reg         hcond_q;
    wire        hcond_d = above ? 1'b1 :
                          (at_low ? 1'b0 : hcond_q);
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            hcond_q <= 1'b0;
        else if (ctrl_tick)
            hcond_q <= hcond_d;
    end
    reg want_b;
    always @* begin
        case (mode)
            `GSW_MODE_FIX_A:     want_b = 1'b0;
            `GSW_MODE_EXT:       want_b = gain_sel_in;
            `GSW_MODE_TQ, `GSW_MODE_DEV, `GSW_MODE_ACC,
            `GSW_MODE_SREF, `GSW_MODE_PREF, `GSW_MODE_ASPD:
                                 want_b = hcond_d;
            `GSW_MODE_PREF_ASPD: want_b = hcond_d && spd_ok;
            `GSW_MODE_FIX_B:     want_b = 1'b1;
            `GSW_MODE_POS_DONE:  want_b = pos_done_in;
            default:             want_b = 1'b0;
        endcase
    end
    // ------------------------------------------------------------
    // switch sequencer: delay, then position gain ramp
    // ------------------------------------------------------------
    reg [1:0]  st_q;
    reg        set_b_q;
    reg        target_q;
    reg [15:0] dcnt_q;
    reg [15:0] pg_q;
    reg [31:0] acc_q;
    reg [15:0] span_q;
    wire [15:0] pg_tgt = set_b_q ? cfg_q[`GSW_IDX_POS_GAIN_B] :
                                   cfg_q[`GSW_IDX_POS_GAIN_A];
    wire [15:0] pg_new = target_q ? cfg_q[`GSW_IDX_POS_GAIN_B] :
                                    cfg_q[`GSW_IDX_POS_GAIN_A];
    wire [15:0] span_new = (pg_new > pg_q) ? (pg_new - pg_q) :
                                             (pg_q - pg_new);
    wire [15:0] dcnt_inc = dcnt_q + 16'h0001;
    // one unit of gain per sys_clk cycle at most; fine while a control
    // cycle spans many clocks, else the ramp runs late
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            st_q     <= ST_IDLE;
            set_b_q  <= 1'b0;
            target_q <= 1'b0;
            dcnt_q   <= 16'h0000;
            pg_q     <= `GSW_RST_POS_GAIN;
            acc_q    <= 32'h0000_0000;
            span_q   <= 16'h0000;
        end else begin
            case (st_q)
                ST_IDLE: begin
                    pg_q <= pg_tgt;
                    if (ctrl_tick && want_b != set_b_q) begin
                        target_q <= want_b;
                        dcnt_q   <= 16'h0000;
                        st_q     <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (want_b != target_q) begin
                        st_q <= ST_IDLE;
                    end else if (dcnt_q >= delay_cyc) begin
                        set_b_q <= target_q;
                        span_q  <= span_new;
                        acc_q   <= 32'h0000_0000;
                        st_q    <= ST_RAMP;
                    end else if (ctrl_tick) begin
                        dcnt_q <= dcnt_inc;
                    end
                end
                ST_RAMP: begin
                    if (ramp_cyc == 16'h0000 || pg_q == pg_tgt) begin
                        pg_q <= pg_tgt;
                        st_q <= ST_IDLE;
                    end else if (acc_q >= {16'h0000, ramp_cyc}) begin
                        pg_q  <= (pg_tgt > pg_q) ? pg_q + 16'h0001 :
                                                   pg_q - 16'h0001;
                        acc_q <= acc_q - {16'h0000, ramp_cyc} +
                                 (ctrl_tick ? {16'h0000, span_q} :
                                              32'h0000_0000);
                    end else if (ctrl_tick) begin
                        acc_q <= acc_q + {16'h0000, span_q};
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end
    // ------------------------------------------------------------
    // speed sources
    // ------------------------------------------------------------
    reg  [31:0]        pos_prev_q;
    reg  signed [15:0] enc_raw_q;
    wire signed [15:0] enc_filt;
    wire [31:0]        pos_diff = encoder_pos - pos_prev_q;
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            pos_prev_q <= 32'h0000_0000;
            enc_raw_q  <= 16'sh0000;
        end else if (ctrl_tick) begin
            pos_prev_q <= encoder_pos;
            enc_raw_q  <= pos_diff[15:0];
        end
    end
    gsw_lpf u_enc_lpf (
        .sys_clk   (sys_clk),
        .arst_n    (arst_n),
        .tick      (ctrl_tick),
        .x_in      (enc_raw_q),
        .filt_time (cfg_q[`GSW_IDX_ENC_FILT]),
        .y_q       (enc_filt)
    );
    // observer: torque drives the estimate, encoder error corrects it
    reg  signed [31:0] obs_q;
    wire signed [31:0] enc_ext = {{8{enc_raw_q[15]}}, enc_raw_q,
                                  {`GSW_FRAC_BITS{1'b0}}};
    wire signed [31:0] obs_err = enc_ext - obs_q;
    wire signed [43:0] obs_cor = obs_err *
                                 $signed({1'b0, cfg_q[`GSW_IDX_OBS_GAIN][9:0]});
    wire signed [43:0] obs_cor_s = obs_cor >>> `GSW_OBS_GAIN_SHIFT;
    wire signed [31:0] tq_ext = {{16{torque_cmd[15]}}, torque_cmd};
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n)
            obs_q <= 32'h0000_0000;
        else if (ctrl_tick)
            obs_q <= obs_q + (tq_ext >>> `GSW_OBS_TQ_SHIFT) +
                     obs_cor_s[31:0];
    end
    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            speed_loop_gain     <= `GSW_RST_SPD_GAIN;
            speed_integral_time <= `GSW_RST_INTEG;
            position_loop_gain  <= `GSW_RST_POS_GAIN;
            torque_filter_time  <= `GSW_RST_TQ_FILT;
            gain_set_b          <= 1'b0;
            speed_feedback      <= 16'sh0000;
            observed_speed      <= 16'sh0000;
        end else begin
            speed_loop_gain     <= set_b_q ? cfg_q[`GSW_IDX_SPD_GAIN_B] :
                                             cfg_q[`GSW_IDX_SPD_GAIN_A];
            speed_integral_time <= set_b_q ? cfg_q[`GSW_IDX_INTEG_B] :
                                             cfg_q[`GSW_IDX_INTEG_A];
            torque_filter_time  <= set_b_q ? cfg_q[`GSW_IDX_TQ_FILT_B] :
                                             cfg_q[`GSW_IDX_TQ_FILT_A];
            position_loop_gain  <= pg_q;
            gain_set_b          <= set_b_q;
            speed_feedback      <= fb_sel ? obs_q[23:8] : enc_filt;
            observed_speed      <= obs_q[23:8];
        end
    end
    // ------------------------------------------------------------
    // apb slave: answer prepared in setup, no wait states
    // ------------------------------------------------------------
    reg [31:0] rd_val;
    reg        rd_ok;
    always @* begin
        rd_val = 32'h0000_0000;
        rd_ok  = 1'b1;
        if (cfg_hit) begin
            rd_val = {16'h0000, cfg_q[reg_idx]};
        end else if (paddr[1:0] != 2'h0) begin
            rd_ok = 1'b0;
        end else begin
            case (reg_idx)
                `GSW_IDX_STATUS:
                    rd_val = {29'h0, st_q == ST_RAMP, st_q == ST_WAIT,
                              set_b_q};
                `GSW_IDX_POS_GAIN_NOW: rd_val = {16'h0000, pg_q};
                `GSW_IDX_FB_SPEED:
                    rd_val = {{16{speed_feedback[15]}}, speed_feedback};
                `GSW_IDX_OBS_SPEED:
                    rd_val = {{16{obs_q[23]}}, obs_q[23:8]};
                `GSW_IDX_ENC_SPEED:
                    rd_val = {{16{enc_filt[15]}}, enc_filt};
                default: rd_ok = 1'b0;
            endcase
            // upper half is unmapped: no data may leak out on a refusal
            if (paddr[7]) begin
                rd_val = 32'h0000_0000;
                rd_ok  = 1'b0;
            end
        end
    end
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (psel && !penable) begin
            pready  <= 1'b1;
            prdata  <= pwrite ? 32'h0000_0000 : rd_val;
            // writes to status words and unmapped words are refused
            pslverr <= pwrite ? !cfg_hit : !rd_ok;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end
    end

endmodule
`default_nettype wire

// File: test_gsw.sv
/* bench: apb tasks, gain set modes and speed feedback.
   assumes gsw_host makes ticks and encoder motion. */
`timescale 1ns/100ps
`default_nettype none
module test_gain_set_and_speed_feedback_select;
    logic sys_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, encoder_pos;
    logic pready, pslverr, ctrl_tick, gain_set_b;
    logic gain_sel_in = 0, pos_done_in = 0;
    logic [15:0] mag [6] = '{default: 16'h0};
    logic [15:0] step = 16'h0021, speed_loop_gain, position_loop_gain;
    logic signed [15:0] speed_feedback, observed_speed;
    int err_total = 0, checks = 0;
    always #12.5 sys_clk = ~sys_clk;
    gsw_host u_host (.sys_clk, .arst_n, .step, .ctrl_tick, .encoder_pos);
    gsw_top dut (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ctrl_tick, .gain_sel_in,
        .pos_done_in, .torque_ref_mag(mag[0]), .pos_dev_mag(mag[1]),
        .accel_mag(mag[2]), .speed_ref_mag(mag[3]), .pos_ref_mag(mag[4]),
        .actual_speed_mag(mag[5]), .encoder_pos, .torque_cmd(16'sh0),
        .speed_loop_gain, .speed_integral_time(), .position_loop_gain,
        .torque_filter_time(), .gain_set_b, .speed_feedback,
        .observed_speed);
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task close_out;
        $display("checks %0d errors %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // read compares data; both directions compare the error flag
    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
              input logic ee);
        int n;
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk);
        penable <= 1;
        n = 0;
        do begin @(posedge sys_clk); n++; end while (pready !== 1 && n < 50);
        if (n >= 50) begin chk("pready", 0, 1); close_out(); end
        if (!w) chk("prdata", prdata, d);
        chk("pslverr", pslverr, ee);
        psel <= 0; penable <= 0;
        // idle edge, so a following call never re-drives psel at once
        @(posedge sys_clk);
    endtask
    task want(input logic b);
        int n;
        n = 0;
        while (gain_set_b !== b && n < 300) begin @(posedge sys_clk); n++; end
        chk("set", gain_set_b, b);
        if (n >= 300) close_out();
    endtask
    // a change inside the hysteresis band must not move the set
    task hold(input logic b);
        repeat (60) @(posedge sys_clk);
        chk("set", gain_set_b, b);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge sys_clk);
        arst_n <= 1;
        @(posedge sys_clk);
        chk("set", gain_set_b, 0);
        xfer(0, 8'h00, 32'h190, 0);
        xfer(0, 8'h04, 32'h7d0, 0);
        xfer(0, 8'h38, 32'h0, 0);
        xfer(0, 8'h58, 32'h0, 1);
        xfer(1, 8'h60, 32'h5, 1);
        xfer(0, 8'he0, 32'h0, 1);
        xfer(1, 8'h10, 32'h300, 0);
        xfer(1, 8'h18, 32'h200, 0);
        xfer(1, 8'h3c, 32'h3, 0);
        xfer(1, 8'h44, 32'h10, 0);
        xfer(1, 8'h48, 32'h0, 0);
        for (int k = 0; k < 6; k++) xfer(1, 8'h20 + 8'(4 * k), 32'hc8, 0);
        xfer(1, 8'h38, 32'h9, 0);
        repeat (12) @(posedge sys_clk);
        chk("set", gain_set_b, 0);
        want(1);
        repeat (4) @(posedge sys_clk);
        chk("spd_gain", speed_loop_gain, 32'h300);
        chk("pos_gain", position_loop_gain, 32'h200);
        gain_sel_in <= 1;
        xfer(1, 8'h38, 32'h0, 0);
        want(0);
        xfer(1, 8'h38, 32'h1, 0);
        want(1);
        gain_sel_in <= 0;
        want(0);
        pos_done_in <= 1;
        xfer(1, 8'h38, 32'ha, 0);
        want(1);
        pos_done_in <= 0;
        want(0);
        for (int m = 2; m < 8; m++) begin
            xfer(1, 8'h38, 32'(m), 0);
            mag[m - 2] <= 16'hd0;
            hold(0);
            mag[m - 2] <= 16'he0;
            want(1);
            mag[m - 2] <= 16'hd0;
            hold(1);
            mag[m - 2] <= 16'hc8;
            want(0);
        end
        xfer(1, 8'h38, 32'h8, 0);
        mag[4] <= 16'hd0;
        mag[5] <= 16'he0;
        hold(0);
        mag[4] <= 16'he0;
        want(1);
        mag[5] <= 16'hc0;
        want(0);
        chk("fb", 32'(speed_feedback), 32'h21);
        xfer(0, 8'h70, 32'h21, 0);
        xfer(1, 8'h50, 32'h1, 0);
        repeat (2) @(posedge sys_clk);
        chk("obs", 32'(observed_speed[15:1]), 32'h10);
        step <= 16'h0;
        repeat (40) @(posedge sys_clk);
        // observer still coasting while the encoder reads standstill
        chk("fb_obs", 32'(speed_feedback != 0), 1);
        xfer(0, 8'h70, 32'h0, 0);
        close_out();
    end
endmodule
`default_nettype wire
